/* bias_cfg_pkg.sv */
`default_nettype none
package bias_cfg_pkg;
  // ==========================================================================
  // register map
  localparam logic [7:0] ADDR_START_DELAY   = 8'h02;
  localparam logic [7:0] ADDR_BOOST_VOLTAGE = 8'h03;
  localparam logic [7:0] ADDR_BOOST_FSW     = 8'h04;

  // ==========================================================================
  // field widths and reset values
  localparam int         DELAY_W         = 4;
  localparam int         VOLT_W          = 5;
  localparam int         FSW_W           = 2;
  localparam logic [3:0] DELAY_RESET     = 4'h2;
  localparam logic [4:0] VOLT_RESET      = 5'h0F;
  localparam logic [1:0] FSW_RESET       = 2'h1;

  // ==========================================================================
  // voltage decode, in units of 0.1 V
  localparam logic [6:0] VOLT_BASE_DV    = 7'h41;

  // frequency decode, in kHz
  localparam logic [9:0] FSW_KHZ_0       = 10'h190;
  localparam logic [9:0] FSW_KHZ_1       = 10'h258;
  localparam logic [9:0] FSW_KHZ_2       = 10'h320;
  localparam logic [9:0] FSW_KHZ_3       = 10'h3E8;

  // ==========================================================================
  // timing: one delay step per tick of the step timebase
  localparam int DELAY_STEP_MS  = 5;
  localparam int CLK_KHZ        = 100000;
  localparam int STEP_CYCLES    = DELAY_STEP_MS * CLK_KHZ;
endpackage : bias_cfg_pkg
`default_nettype wire

/* step_timebase.sv */
`timescale 1ns/100ps
`default_nettype none
module step_timebase #(
  parameter int PERIOD = 500000
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  // control
  input  wire logic run_i,
  output logic      tick_o
);
  logic [31:0] cnt_ff;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_ff <= 32'h0;
      tick_o <= 1'b0;
    end else if (!run_i) begin
      cnt_ff <= 32'h0;
      tick_o <= 1'b0;
    end else if (cnt_ff == 32'(PERIOD - 1)) begin
      cnt_ff <= 32'h0;
      tick_o <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 32'h1;
      tick_o <= 1'b0;
    end
  end
endmodule // step_timebase
`default_nettype wire

/* bias_config_registers.sv */
`timescale 1ns/100ps
`default_nettype none
module bias_config_registers
  import bias_cfg_pkg::*;
#(
  parameter int STEP_CYCLES_P = STEP_CYCLES
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  // register port
  input  wire logic [7:0] reg_addr_i,
  input  wire logic       reg_wr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  // supply monitor
  input  wire logic       input_supply_good_i,
  // converter controls
  output logic      [6:0] boost_target_dv_o,
  output logic      [1:0] boost_switch_frequency_o,
  output logic      [9:0] boost_switch_khz_o,
  output logic            regulator_enable_o
);

  // ==========================================================================
  // configuration registers
  logic [DELAY_W-1:0] regulator_start_delay_ff;
  logic [VOLT_W-1:0]  boost_voltage_code_ff;
  logic               wr_delay;
  logic               wr_volt;
  logic               wr_fsw;

  // ==========================================================================
  // write decode; one strobe per register so no address touches two fields
  assign wr_delay = reg_wr_i && (reg_addr_i == ADDR_START_DELAY);
  assign wr_volt  = reg_wr_i && (reg_addr_i == ADDR_BOOST_VOLTAGE);
  assign wr_fsw   = reg_wr_i && (reg_addr_i == ADDR_BOOST_FSW);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      regulator_start_delay_ff <= DELAY_RESET;
    end else if (wr_delay) begin
      regulator_start_delay_ff <= reg_wdata_i[DELAY_W-1:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      boost_voltage_code_ff <= VOLT_RESET;
    end else if (wr_volt) begin
      boost_voltage_code_ff <= reg_wdata_i[VOLT_W-1:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      boost_switch_frequency_o <= FSW_RESET;
    end else if (wr_fsw) begin
      boost_switch_frequency_o <= reg_wdata_i[FSW_W-1:0];
    end
  end

  // ==========================================================================
  // read back; unused upper bits and unmapped addresses give zero
  logic [7:0] nxt_rdata;

  always_comb begin
    nxt_rdata = 8'h00;
    unique case (reg_addr_i)
      ADDR_START_DELAY:   nxt_rdata = {4'h0, regulator_start_delay_ff};
      ADDR_BOOST_VOLTAGE: nxt_rdata = {3'h0, boost_voltage_code_ff};
      ADDR_BOOST_FSW:     nxt_rdata = {6'h00, boost_switch_frequency_o};
      default:            nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= nxt_rdata;
    end
  end

  // ==========================================================================
  // converter targets
  logic [6:0] nxt_target_dv;
  logic [9:0] nxt_khz;

  // 0.1 V units, so the code is only an offset above the 6.5 V floor
  assign nxt_target_dv = VOLT_BASE_DV + {2'h0, boost_voltage_code_ff};

  always_comb begin
    nxt_khz = FSW_KHZ_0;
    unique case (boost_switch_frequency_o)
      2'h0: nxt_khz = FSW_KHZ_0;
      2'h1: nxt_khz = FSW_KHZ_1;
      2'h2: nxt_khz = FSW_KHZ_2;
      2'h3: nxt_khz = FSW_KHZ_3;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      boost_target_dv_o <= 7'h00;
    end else begin
      boost_target_dv_o <= nxt_target_dv;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      boost_switch_khz_o <= 10'h000;
    end else begin
      boost_switch_khz_o <= nxt_khz;
    end
  end

  // ==========================================================================
  // start-up delay sequencer
  typedef enum logic [2:0] {
    ST_OFF  = 3'b001,
    ST_WAIT = 3'b010,
    ST_ON   = 3'b100
  } seq_state_t;

  seq_state_t         state_ff;
  logic [DELAY_W-1:0] steps_ff;
  logic               step_tick;
  logic               timing;
  logic               start_now;
  logic               last_step;

  // timebase stays cleared outside the wait so every step is a full 5 ms
  assign timing = (state_ff == ST_WAIT) && input_supply_good_i;
  // a zero delay code skips ST_WAIT and enables straight from ST_OFF
  assign start_now = (regulator_start_delay_ff == 4'h0);
  assign last_step = step_tick && (steps_ff == 4'h1);

  step_timebase #(
    .PERIOD (STEP_CYCLES_P)
  ) u_timebase (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .run_i   (timing),
    .tick_o  (step_tick)
  );

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_ff <= ST_OFF;
    end else begin
      unique case (state_ff)
        ST_OFF: begin
          if (input_supply_good_i && start_now) begin
            state_ff <= ST_ON;
          end else if (input_supply_good_i) begin
            state_ff <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (!input_supply_good_i) begin
            state_ff <= ST_OFF;
          end else if (last_step) begin
            state_ff <= ST_ON;
          end
        end
        ST_ON: begin
          if (!input_supply_good_i) begin
            state_ff <= ST_OFF;
          end
        end
        default: begin
          state_ff <= ST_OFF;
        end
      endcase
    end
  end

  // ==========================================================================
  // step counter; code is sampled on entry, later writes wait for the next power-up
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      steps_ff <= 4'h0;
    end else if (state_ff == ST_OFF) begin
      steps_ff <= regulator_start_delay_ff;
    end else if (state_ff == ST_WAIT && step_tick) begin
      steps_ff <= steps_ff - 4'h1;
    end
  end

  // ==========================================================================
  // regulator enable; supply loss wins over every state
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      regulator_enable_o <= 1'b0;
    end else if (!input_supply_good_i) begin
      regulator_enable_o <= 1'b0;
    end else if (state_ff == ST_OFF) begin
      regulator_enable_o <= start_now;
    end else if (state_ff == ST_WAIT) begin
      regulator_enable_o <= last_step;
    end else if (state_ff != ST_ON) begin
      regulator_enable_o <= 1'b0;
    end
  end

endmodule // bias_config_registers
`default_nettype wire

/* bias_config_registers_props.sv */
`timescale 1ns/100ps
`default_nettype none
module bias_config_registers_props
  import bias_cfg_pkg::*;
#(
  parameter int STEP_CYCLES_P = 4
) (
  // watched ports
  input wire logic       clk_i,
  input wire logic       rst_b_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic       reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       input_supply_good_i,
  input wire logic [6:0] boost_target_dv_o,
  input wire logic [1:0] boost_switch_frequency_o,
  input wire logic [9:0] boost_switch_khz_o,
  input wire logic       regulator_enable_o
);
  localparam logic [9:0] KHZ [4] = '{FSW_KHZ_0, FSW_KHZ_1, FSW_KHZ_2, FSW_KHZ_3};
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // ==========
  // properties
  sequence s_wr(a); reg_wr_i && reg_addr_i == a; endsequence
  sequence s_rd(a); reg_rd_i && reg_addr_i == a; endsequence
  property p_volt_wr;
    s_wr(ADDR_BOOST_VOLTAGE) |-> ##2
      boost_target_dv_o == VOLT_BASE_DV + 7'($past(reg_wdata_i[4:0], 2));
  endproperty
  a_volt_range: assert property ($past(rst_b_i) |-> boost_target_dv_o inside {[65:96]})
    else $error("boost target out of range");
  a_khz_decode: assert property ($past(rst_b_i) && $stable(boost_switch_frequency_o) |->
    boost_switch_khz_o == KHZ[boost_switch_frequency_o]) else $error("khz decode wrong");
  a_fsw_write: assert property (s_wr(ADDR_BOOST_FSW) |=>
    boost_switch_frequency_o == 2'($past(reg_wdata_i))) else $error("fsw write lost");
  a_fsw_hold: assert property (!(reg_wr_i && reg_addr_i == ADDR_BOOST_FSW) |=>
    $stable(boost_switch_frequency_o)) else $error("fsw changed without write");
  a_volt_write: assert property (p_volt_wr) else $error("boost target not updated");
  a_delay_upper: assert property (s_rd(ADDR_START_DELAY) |=> reg_rdata_o[7:4] == 4'h0)
    else $error("delay upper bits set");
  a_volt_upper: assert property (s_rd(ADDR_BOOST_VOLTAGE) |=> reg_rdata_o[7:5] == 3'h0)
    else $error("voltage upper bits set");
  a_enable_drop: assert property (!input_supply_good_i |=> !regulator_enable_o)
    else $error("enable without supply");
endmodule // bias_config_registers_props
`default_nettype wire

/* reg_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module reg_host_model (
  // register port toward the device
  input  wire logic       clk_i,
  output logic      [7:0] reg_addr_o,
  output logic            reg_wr_o,
  output logic      [7:0] reg_wdata_o,
  output logic            reg_rd_o
);
  initial begin
    reg_addr_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_wdata_o = 8'h00;
    reg_rd_o = 1'b0;
  end
  // one-cycle strobe; released data inverted so stale bytes never pass
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = w;
    reg_rd_o = !w;
    @(negedge clk_i);
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_wdata_o = ~d;
  endtask
endmodule // reg_host_model
`default_nettype wire

/* bias_config_registers_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module bias_config_registers_tb;
  import bias_cfg_pkg::*;
  localparam int STEP = 4;
  logic       clk_i = 1'b0;
  logic       rst_b_i = 1'b0;
  logic       good = 1'b0;
  logic [7:0] addr, wdata, rdata;
  logic       wr, rd, en;
  logic [6:0] dv;
  logic [1:0] fcode;
  logic [9:0] khz;
  logic [7:0] expq[$];
  logic [9:0] ktab [4] = '{10'h190, 10'h258, 10'h320, 10'h3E8};
  int         err_count = 0;
  int         checks_done = 0;
  int         cyc = 0;
  reg_host_model host (.clk_i(clk_i), .reg_addr_o(addr), .reg_wr_o(wr), .reg_wdata_o(wdata),
    .reg_rd_o(rd));
  bias_config_registers #(.STEP_CYCLES_P(STEP)) dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .input_supply_good_i(good), .boost_target_dv_o(dv), .boost_switch_frequency_o(fcode),
    .boost_switch_khz_o(khz), .regulator_enable_o(en));
  initial forever #5 clk_i = ~clk_i;
  // ===========
  // scoreboard
  task automatic cmp(input string n, input logic [9:0] e, input logic [9:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic cmp_rdata(input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] rdata exp %h got %h", e, g);
    end
  endtask
  task automatic stop_test();
    $display("mismatches %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
    expq.push_back(e);
    host.acc(1'b0, a, 8'h00);
  endtask
  always @(posedge clk_i) if (rd) begin
    @(negedge clk_i);
    cmp_rdata(expq.pop_front(), rdata);
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc > 3000) begin
      err_count++;
      stop_test();
    end
  end
  // glitch drops the supply once mid-wait, so the full delay must restart
  task automatic power(input logic [3:0] code, input int glitch);
    int n;
    host.acc(1'b1, ADDR_START_DELAY, {4'($urandom), code});
    good = 1'b1;
    repeat (glitch) @(negedge clk_i);
    if (glitch > 0) begin
      good = 1'b0;
      @(negedge clk_i);
      good = 1'b1;
    end
    n = 0;
    while (en !== 1'b1 && n < 200) begin
      @(negedge clk_i);
      n++;
    end
    cmp("delay", (code == 4'h0) ? 10'h001 : 10'(code * STEP + 2), 10'(n));
    good = 1'b0;
    @(negedge clk_i);
    cmp("enable", 10'h000, {9'h0, en});
  endtask
  initial begin
    logic [7:0] d;
    void'($urandom(14));
    repeat (8) @(negedge clk_i);
    rst_b_i = 1'b1;
    rd_exp(ADDR_START_DELAY, 8'h02);
    rd_exp(ADDR_BOOST_VOLTAGE, 8'h0F);
    rd_exp(ADDR_BOOST_FSW, 8'h01);
    cmp("target", 10'h050, {3'h0, dv});
    $display("reset values done");
    for (int i = 0; i < 12; i++) begin
      d = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : {6'($urandom), 2'(i)};
      host.acc(1'b1, ADDR_START_DELAY, d);
      host.acc(1'b1, ADDR_BOOST_VOLTAGE, d);
      host.acc(1'b1, ADDR_BOOST_FSW, d);
      rd_exp(ADDR_START_DELAY, d & 8'h0F);
      rd_exp(ADDR_BOOST_VOLTAGE, d & 8'h1F);
      rd_exp(ADDR_BOOST_FSW, d & 8'h03);
      cmp("target", {3'h0, 7'h41 + 7'(d[4:0])}, {3'h0, dv});
      cmp("khz", ktab[d[1:0]], khz);
      cmp("fsw code", {8'h00, d[1:0]}, {8'h00, fcode});
    end
    host.acc(1'b1, 8'h05, 8'hFF);
    rd_exp(8'h05, 8'h00);
    $display("register access done");
    power(4'h0, 0);
    power(4'h2, 0);
    power(4'($urandom), 0);
    power(4'h3, 6);
    $display("power up done");
    rst_b_i = 1'b0;
    repeat (2) @(negedge clk_i);
    rst_b_i = 1'b1;
    rd_exp(ADDR_START_DELAY, 8'h02);
    rd_exp(ADDR_BOOST_VOLTAGE, 8'h0F);
    rd_exp(ADDR_BOOST_FSW, 8'h01);
    repeat (2) @(negedge clk_i);
    $display("second reset done");
    stop_test();
  end
endmodule // bias_config_registers_tb
bind bias_config_registers bias_config_registers_props #(.STEP_CYCLES_P(STEP_CYCLES_P)) u_props (
  .clk_i, .rst_b_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i, .reg_rdata_o,
  .input_supply_good_i, .boost_target_dv_o, .boost_switch_frequency_o, .boost_switch_khz_o,
  .regulator_enable_o);
`default_nettype wire
